// *** cam_ctl_params.svh ***
// Purpose: constants of the cam controller control-input logic
// Assumes: 25 MHz core clock
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef CAM_CTL_PARAMS_SVH
`define CAM_CTL_PARAMS_SVH

`define T_CLK_NS 40
// reaction bound of the release and gate inputs
`define T_REACT_US 500
`define REACT_CYC ((`T_REACT_US * 1000) / `T_CLK_NS)
// overload must persist this long before an output trips
`define T_OVL_US 100
`define OVL_CYC ((`T_OVL_US * 1000 + `T_CLK_NS - 1) / `T_CLK_NS)
// outputs stay frozen this long after an external zero offset
`define T_FREEZE_MS 5000
`define FREEZE_CYC (`T_FREEZE_MS * (1000000 / `T_CLK_NS))

`define POS_W 16
`define PROG_W 6
`define OUT_W 16
`define SPEED_W 16
`define OVL_W 12
`define FRZ_W 27
`define CAM_TOTAL 2000
`define CAM_AW 11
`define CAM_DW 32
`define TRK10_BIT 9
`define POS_RST 16'h0000
`define PROG_RST 6'h00

`endif

// *** cam_ctl_pkg.sv ***
// Purpose: types shared by the control-input logic
// Assumes: cam_ctl_params.svh holds all numbers
// Notes: none
`include "cam_ctl_params.svh"
package cam_ctl_pkg;

   typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_SAVE} phase_t;

   // raw control inputs, carried together through the synchroniser
   typedef struct packed {
      logic count_release_n;
      logic output_gate;
      logic program_take;
      logic parameter_unlock;
      logic store_n;
      logic clear_n;
      logic clear_p;
      logic track10;
      logic [`PROG_W-1:0] program_select;
   } ctl_in_t;

   typedef struct packed {
      phase_t st;
      logic [`POS_W-1:0] pos;
      logic [`PROG_W-1:0] active_prog;
      logic [`SPEED_W-1:0] speed_cnt;
      logic [`SPEED_W-1:0] speed_per;
      logic [`OVL_W-1:0] ovl_cnt;
      logic [`OUT_W-1:0] tripped;
      logic err;
      logic [`FRZ_W-1:0] zfrz;
      logic [`OUT_W-1:0] cam_out;
      logic [`POS_W-1:0] nv_wr_data;
      logic cfg_refused;
      logic prev_store_n;
      logic prev_trk10;
   } state_t;

endpackage : cam_ctl_pkg

// *** sync_bits.sv ***
// Purpose: two-stage synchroniser for a group of level inputs
// Assumes: one clock, synchronous active-high reset
// Notes: first stage feeds only the second stage
module sync_bits #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] out_ff;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         // live levels, so no false edge or clear follows reset
         meta_ff <= din;
         out_ff <= din;
      end
      else
      begin
         meta_ff <= din;
         out_ff <= meta_ff;
      end
   end

   assign dout = out_ff;

endmodule : sync_bits

// *** cam_control_input_logic.sv ***
// Purpose: control-input logic of a cam controller
// Assumes: encoder decoding and cam evaluation sit outside this block
// Notes: control inputs are resynchronised, so each reacts three cycles late
//
// Behaviour
// - count runs while release input low, holds while high.
// - speed measurement keeps running while the count is held.
// - release input acts within half a millisecond.
// - incremental mode: outputs off while gate low, follow program while high.
// - gate changes reach the outputs within half a millisecond.
// - program-select inputs form a plain binary program number.
// - take-over input high captures the selected program number.
// - configuration writes accepted only while parameter unlock is high.
// - a falling edge on the save input, and nothing else, starts saves.
// - save writes position to nonvolatile store; power-up loads it back.
// - count forced and held at zero while either clear is active.
// - sustained overload switches affected outputs off and flags an error.
// - storage holds two thousand programmable cams in total.
// - with zero option, rising track-ten edge zeroes the position.
// - outputs stay frozen during zero correction, up to five seconds; a new trip still switches its output off.
// - with zero option, track ten no longer feeds the position.
`include "cam_ctl_params.svh"
module cam_control_input_logic #(
   parameter int unsigned FREEZE_CYC = `FREEZE_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // machine control inputs
   input wire cam_ctl_pkg::ctl_in_t ctl_in,
   // mode straps
   input wire logic incr_mode,
   input wire logic external_zero_option,
   // position sources
   input wire logic count_step,
   input wire logic count_up,
   input wire logic [`POS_W-1:0] abs_track,
   // cam evaluation and output drivers
   input wire logic [`OUT_W-1:0] cam_match,
   input wire logic [`OUT_W-1:0] overload,
   input wire logic err_clear,
   output logic [`OUT_W-1:0] cam_out,
   output logic error_flag,
   // status
   output logic [`POS_W-1:0] position,
   output logic [`PROG_W-1:0] active_program,
   output logic [`SPEED_W-1:0] speed_period,
   output logic zero_busy,
   // nonvolatile position store
   output logic nv_rd_req,
   input wire logic nv_rd_valid,
   input wire logic [`POS_W-1:0] nv_rd_data,
   output logic nv_wr_req,
   output logic [`POS_W-1:0] nv_wr_data,
   input wire logic nv_wr_ack,
   // cam table access
   input wire logic cfg_wr_en,
   input wire logic [`CAM_AW-1:0] cfg_addr,
   input wire logic [`CAM_DW-1:0] cfg_wr_data,
   output logic [`CAM_DW-1:0] cfg_rd_data,
   output logic cfg_wr_refused
);

   localparam logic [`OVL_W-1:0] OVL_LAST = `OVL_W'(`OVL_CYC - 1);
   localparam logic [`FRZ_W-1:0] FRZ_LOAD = `FRZ_W'(FREEZE_CYC);
   localparam int unsigned REACT_LIMIT = `REACT_CYC;

   cam_ctl_pkg::ctl_in_t ci;
   cam_ctl_pkg::state_t s_ff;
   cam_ctl_pkg::state_t nxt_s;
   logic store_fall;
   logic zero_rise;
   logic clr;
   logic [`POS_W-1:0] abs_pos;
   logic [`OUT_W-1:0] drive;
   logic [`OUT_W-1:0] new_trip;

   // cam table; each entry is one cam's switch points
   logic [`CAM_DW-1:0] cam_mem [0:`CAM_TOTAL-1];
   logic [`CAM_DW-1:0] cfg_rd_ff;

   // every control input passes two flops before use
   sync_bits #(.W($bits(cam_ctl_pkg::ctl_in_t))) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .din(ctl_in),
      .dout(ci)
   );

   assign store_fall = s_ff.prev_store_n & ~ci.store_n;
   assign zero_rise = external_zero_option & ~s_ff.prev_trk10
      & ci.track10;
   assign clr = ~ci.clear_n | ci.clear_p;

   // track ten is the zero input when the option is fitted
   always_comb
   begin
      abs_pos = abs_track;
      if (external_zero_option)
      begin
         abs_pos[`TRK10_BIT] = 1'b0;
      end
   end

   always_comb
   begin
      nxt_s = s_ff;
      new_trip = '0;
      drive = '0;
      nxt_s.prev_store_n = ci.store_n;
      nxt_s.prev_trk10 = ci.track10;
      nxt_s.cfg_refused = cfg_wr_en & ~ci.parameter_unlock;

      case (s_ff.st)
         cam_ctl_pkg::ST_BOOT:
         begin
            if (nv_rd_valid)
            begin
               nxt_s.pos = nv_rd_data;
               nxt_s.st = cam_ctl_pkg::ST_RUN;
            end
         end
         cam_ctl_pkg::ST_RUN:
         begin
            if (store_fall)
            begin
               // captured in the edge cycle, before any clear can act
               nxt_s.nv_wr_data = s_ff.pos;
               nxt_s.st = cam_ctl_pkg::ST_SAVE;
            end
         end
         cam_ctl_pkg::ST_SAVE:
         begin
            if (nv_wr_ack)
            begin
               nxt_s.st = cam_ctl_pkg::ST_RUN;
            end
         end
         default:
         begin
            nxt_s.st = cam_ctl_pkg::ST_BOOT;
         end
      endcase

      // position: clear beats zero offset beats hold beats counting
      if (s_ff.st != cam_ctl_pkg::ST_BOOT)
      begin
         if (clr)
         begin
            nxt_s.pos = '0;
         end
         else if (zero_rise)
         begin
            nxt_s.pos = '0;
         end
         else if (ci.count_release_n)
         begin
            nxt_s.pos = s_ff.pos;
         end
         else if (!incr_mode)
         begin
            nxt_s.pos = abs_pos;
         end
         else if (count_step)
         begin
            nxt_s.pos = count_up ? s_ff.pos + `POS_W'(1)
               : s_ff.pos - `POS_W'(1);
         end
      end

      // period between steps, independent of the count hold
      if (count_step)
      begin
         nxt_s.speed_per = s_ff.speed_cnt;
         nxt_s.speed_cnt = '0;
      end
      else if (s_ff.speed_cnt != '1)
      begin
         nxt_s.speed_cnt = s_ff.speed_cnt + `SPEED_W'(1);
      end

      if (ci.program_take)
      begin
         nxt_s.active_prog = ci.program_select;
      end

      // one shared timer; a brief spike on one driver trips it if other drivers kept the timer running
      if (|(overload & ~s_ff.tripped))
      begin
         if (s_ff.ovl_cnt == OVL_LAST)
         begin
            new_trip = overload;
            nxt_s.ovl_cnt = '0;
         end
         else
         begin
            nxt_s.ovl_cnt = s_ff.ovl_cnt + `OVL_W'(1);
         end
      end
      else
      begin
         nxt_s.ovl_cnt = '0;
      end
      // a new trip in the clear cycle survives the clear
      if (err_clear)
      begin
         nxt_s.tripped = new_trip;
         nxt_s.err = |new_trip;
      end
      else
      begin
         nxt_s.tripped = s_ff.tripped | new_trip;
         nxt_s.err = s_ff.err | (|new_trip);
      end

      if (zero_rise)
      begin
         nxt_s.zfrz = FRZ_LOAD;
      end
      else if (s_ff.zfrz != '0)
      begin
         nxt_s.zfrz = s_ff.zfrz - `FRZ_W'(1);
      end

      if (s_ff.st != cam_ctl_pkg::ST_BOOT)
      begin
         drive = cam_match;
      end
      if (incr_mode && !ci.output_gate)
      begin
         drive = '0;
      end
      if (zero_rise || s_ff.zfrz != '0)
      begin
         drive = s_ff.cam_out;
      end
      // tripped outputs stay off even while frozen
      nxt_s.cam_out = drive & ~nxt_s.tripped;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s_ff <= '{st: cam_ctl_pkg::ST_BOOT, pos: `POS_RST,
            active_prog: `PROG_RST, default: '0};
         s_ff.prev_store_n <= 1'b1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (cfg_wr_en && ci.parameter_unlock)
      begin
         cam_mem[cfg_addr] <= cfg_wr_data;
      end
      cfg_rd_ff <= cam_mem[cfg_addr];
   end

   assign cam_out = s_ff.cam_out;
   assign error_flag = s_ff.err;
   assign position = s_ff.pos;
   assign active_program = s_ff.active_prog;
   assign speed_period = s_ff.speed_per;
   assign zero_busy = s_ff.zfrz != '0;
   assign nv_rd_req = s_ff.st == cam_ctl_pkg::ST_BOOT;
   assign nv_wr_req = s_ff.st == cam_ctl_pkg::ST_SAVE;
   assign nv_wr_data = s_ff.nv_wr_data;
   assign cfg_rd_data = cfg_rd_ff;
   assign cfg_wr_refused = s_ff.cfg_refused;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   hold_count_a: assert property (
      s_ff.st != cam_ctl_pkg::ST_BOOT && ci.count_release_n && !clr
      && !zero_rise |=> $stable(position))
      else $error("count moved while release held");
   speed_run_a: assert property (
      ci.count_release_n && count_step
      |=> speed_period == $past(s_ff.speed_cnt))
      else $error("speed not measured during hold");
   gate_off_a: assert property (
      (incr_mode && !ctl_in.output_gate && s_ff.zfrz == '0 && !zero_rise)
      [*4] |-> cam_out == '0)
      else $error("outputs on with gate low");
   react_a: assert property (
      REACT_LIMIT >= 3 && $changed(ctl_in.output_gate)
      |-> ##2 ci.output_gate == $past(ctl_in.output_gate, 2))
      else $error("gate sample too late");
   prog_take_a: assert property (
      ci.program_take |=> active_program == $past(ci.program_select))
      else $error("program number not taken");
   unlock_a: assert property (
      cfg_wr_en && !ci.parameter_unlock |=> cfg_wr_refused)
      else $error("locked write not refused");
   save_edge_a: assert property (
      $rose(nv_wr_req) |-> $past(store_fall)
      && nv_wr_data == $past(position))
      else $error("save without falling edge");
   boot_load_a: assert property (
      nv_rd_req && nv_rd_valid |=> !nv_rd_req
      && position == $past(nv_rd_data))
      else $error("start position not loaded");
   clear_zero_a: assert property (
      s_ff.st != cam_ctl_pkg::ST_BOOT && clr |=> position == '0)
      else $error("clear did not zero count");
   trip_off_a: assert property (
      (s_ff.tripped & cam_out) == '0 && (s_ff.tripped == '0 || error_flag))
      else $error("tripped output still on");
   zero_set_a: assert property (
      s_ff.st != cam_ctl_pkg::ST_BOOT && zero_rise
      |=> position == '0 && zero_busy)
      else $error("zero offset not applied");
   freeze_a: assert property (
      zero_busy && s_ff.tripped == '0 ##1 s_ff.tripped == '0
      |-> $stable(cam_out))
      else $error("outputs moved during freeze");
   abs_mask_a: assert property (
      s_ff.st != cam_ctl_pkg::ST_BOOT && !incr_mode && external_zero_option
      |=> position[`TRK10_BIT] == 1'b0)
      else $error("track ten used for position");
   save_c: cover property ($rose(nv_wr_req) ##[1:20] $fell(nv_wr_req));
   zero_c: cover property (zero_rise ##1 zero_busy);
   take_c: cover property (ci.program_take ##1 $changed(active_program));
   trip_c: cover property ($rose(error_flag));

endmodule : cam_control_input_logic

// *** machine_side.sv ***
// Purpose: machine-side model holding the saved start position
// Assumes: store requests are levels held until answered
// Notes: slow stretches the answer delay; idle read data keeps toggling
module machine_side #(
   parameter logic [15:0] START_POS = 16'h0123
) (
   // clock
   input wire logic core_clk,
   // answer speed
   input wire logic slow,
   // position store
   input wire logic nv_rd_req,
   output logic nv_rd_valid,
   output logic [15:0] nv_rd_data,
   input wire logic nv_wr_req,
   input wire logic [15:0] nv_wr_data,
   output logic nv_wr_ack
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] saved = START_POS;
   int cnt = 0;
   initial
   begin
      nv_rd_valid = 1'b0;
      nv_rd_data = 16'h0000;
      nv_wr_ack = 1'b0;
   end
   always @(posedge core_clk)
   begin
      nv_rd_valid <= 1'b0;
      nv_wr_ack <= 1'b0;
      // not a stale copy, so a late sample cannot pass by luck
      nv_rd_data <= ~nv_rd_data;
      if (!(nv_rd_req || nv_wr_req))
         cnt <= 0;
      else if (cnt < (slow ? 9 : 2))
         cnt <= cnt + 1;
      else
      begin
         cnt <= 0;
         if (nv_rd_req)
         begin
            nv_rd_valid <= 1'b1;
            nv_rd_data <= saved;
         end
         else
         begin
            nv_wr_ack <= 1'b1;
            saved <= nv_wr_data;
         end
      end
   end
endmodule : machine_side

// *** cam_control_input_logic_test.sv ***
// Purpose: self-checking bench for the cam control-input logic
// Assumes: 25 MHz clock, freeze count shortened to FRZ cycles
// Notes: drivers queue expected values, a monitor compares them
module cam_control_input_logic_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int FRZ = 20;
   localparam logic [15:0] START = 16'h0123;
   logic core_clk, rst, incr_mode, external_zero_option, slow;
   logic count_step, count_up, err_clear, cfg_wr_en, cfg_wr_refused;
   cam_ctl_pkg::ctl_in_t ctl_in;
   logic [15:0] abs_track, cam_match, overload, cam_out, position, p;
   logic [15:0] speed_period, nv_rd_data, nv_wr_data;
   logic [5:0] active_program;
   logic error_flag, zero_busy, nv_rd_req, nv_rd_valid, nv_wr_req;
   logic nv_wr_ack;
   logic [10:0] cfg_addr;
   logic [31:0] cfg_wr_data, cfg_rd_data, v, d;
   int n_mismatch = 0;
   int total_checks = 0;
   int kq[$];
   logic [31:0] eq[$];
   event look;

   cam_control_input_logic #(.FREEZE_CYC(FRZ)) cam_control_input_logic_i (
      .core_clk, .rst, .ctl_in, .incr_mode, .external_zero_option,
      .count_step, .count_up, .abs_track, .cam_match, .overload,
      .err_clear, .cam_out, .error_flag, .position, .active_program,
      .speed_period, .zero_busy, .nv_rd_req, .nv_rd_valid, .nv_rd_data,
      .nv_wr_req, .nv_wr_data, .nv_wr_ack, .cfg_wr_en, .cfg_addr,
      .cfg_wr_data, .cfg_rd_data, .cfg_wr_refused);
   machine_side #(.START_POS(START)) machine_side_i (
      .core_clk, .slow, .nv_rd_req, .nv_rd_valid, .nv_rd_data,
      .nv_wr_req, .nv_wr_data, .nv_wr_ack);

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // kinds: 0 position 1 outputs 2 program 3 error 4 saved value
   // 5 table read 6 refusal 7 frozen 8 save pending 9 speed period
   // 10 start position request
   function automatic logic [31:0] seen(input int k);
      case (k)
         0: return 32'(position);
         1: return 32'(cam_out);
         2: return 32'(active_program);
         3: return 32'(error_flag);
         4: return 32'(nv_wr_data);
         5: return cfg_rd_data;
         6: return 32'(cfg_wr_refused);
         7: return 32'(zero_busy);
         8: return 32'(nv_wr_req);
         10: return 32'(nv_rd_req);
         default: return 32'(speed_period);
      endcase
   endfunction : seen
   task automatic cmp_val(input int k, input logic [31:0] e);
      total_checks++;
      if (seen(k) !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %0t kind %0d got %h want %h", $time, k, seen(k), e);
      end
   endtask : cmp_val
   initial
   forever
   begin
      @(look);
      while (kq.size() > 0)
         cmp_val(kq.pop_front(), eq.pop_front());
   end
   task automatic note(input int k, input logic [31:0] e);
      kq.push_back(k);
      eq.push_back(e);
      -> look;
   endtask : note
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   // bounded wait; a miss shows up in the compare that follows
   task automatic wait_is(input int k, input logic [31:0] e, input int lim);
      for (int i = 0; i < lim && seen(k) !== e; i++)
         cyc(1);
   endtask : wait_is
   task automatic step(input logic up);
      count_up = up;
      count_step = 1'b1;
      cyc(1);
      count_step = 1'b0;
      cyc(1);
   endtask : step
   task automatic wr(input logic [31:0] dat);
      cfg_wr_data = dat;
      cfg_wr_en = 1'b1;
      cyc(1);
      cfg_wr_en = 1'b0;
   endtask : wr
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      $display("[FAIL] %0t watchdog ran out", $time);
      close_out();
   end

   initial
   begin
      rst = 1'b1;
      ctl_in = '0;
      ctl_in.store_n = 1'b1;
      ctl_in.clear_n = 1'b1;
      {incr_mode, external_zero_option, slow, count_step, count_up} = '0;
      {err_clear, cfg_wr_en, cfg_addr, cfg_wr_data} = '0;
      {abs_track, cam_match, overload} = '0;
      void'($urandom(90));
      incr_mode = 1'b1;
      cyc(16);
      rst = 1'b0;
      cyc(20);
      note(0, START);
      $display("test boot done");
      p = START;
      repeat (1 + $urandom % 8)
      begin
         step(1'b1);
         p++;
      end
      cyc(3);
      note(0, p);
      ctl_in.count_release_n = 1'b1;
      cyc(4);
      repeat (3) step(1'b1);
      cyc(3);
      note(0, p);
      note(9, 1);
      ctl_in.count_release_n = 1'b0;
      cyc(4);
      step(1'b0);
      step(1'b0);
      p -= 2;
      cyc(3);
      note(0, p);
      $display("test count done");
      slow = 1'b1;
      ctl_in.store_n = 1'b0;
      wait_is(8, 1, 10);
      note(4, p);
      wait_is(8, 0, 30); // clear stays inactive meanwhile
      ctl_in.store_n = 1'b1;
      cyc(6);
      note(8, 0);
      $display("test save done");
      // power cycle: the saved count must come back as start position
      rst = 1'b1;
      cyc(3);
      note(10, 1);
      note(0, 0);
      rst = 1'b0;
      wait_is(10, 0, 30);
      note(10, 0);
      note(0, p);
      $display("test restore done");
      repeat (3)
      begin
         v = $urandom;
         ctl_in.program_select = v[5:0];
         ctl_in.program_take = 1'b1;
         cyc(5);
         note(2, v[5:0]);
         ctl_in.program_take = 1'b0;
         cyc(1);
         ctl_in.program_select = ~v[5:0];
         cyc(5);
         note(2, v[5:0]);
      end
      $display("test program done");
      cfg_addr = 11'h7cf;
      d = $urandom;
      ctl_in.parameter_unlock = 1'b1;
      cyc(4);
      wr(d);
      note(6, 0);
      cyc(2);
      note(5, d);
      ctl_in.parameter_unlock = 1'b0;
      cyc(4);
      wr(~d);
      note(6, 1);
      cyc(2);
      note(5, d);
      $display("test table done");
      cam_match = 16'($urandom);
      ctl_in.output_gate = 1'b1;
      cyc(5);
      note(1, cam_match);
      ctl_in.output_gate = 1'b0;
      cyc(5);
      note(1, 0);
      ctl_in.output_gate = 1'b1;
      cam_match = 16'hffff; // coupled outputs share one pattern
      overload = 16'h0001;
      cyc(2400);
      note(3, 0);
      wait_is(3, 1, 200);
      note(1, 16'hfffe);
      overload = 16'h0000;
      err_clear = 1'b1;
      cyc(1);
      err_clear = 1'b0;
      cyc(2);
      note(3, 0);
      note(1, 16'hffff);
      $display("test outputs done");
      external_zero_option = 1'b1;
      ctl_in.track10 = 1'b1; // held until the end of the zero test
      cyc(5);
      note(0, 0);
      note(7, 1);
      cam_match = 16'h00ff;
      cyc(3);
      note(1, 16'hffff);
      cyc(FRZ + 5);
      note(7, 0);
      note(1, 16'h00ff);
      ctl_in.track10 = 1'b0;
      $display("test zero done");
      step(1'b1);
      ctl_in.clear_p = 1'b1;
      cyc(4);
      step(1'b1);
      note(0, 0);
      ctl_in.clear_p = 1'b0;
      ctl_in.clear_n = 1'b0;
      cyc(4);
      step(1'b1);
      note(0, 0);
      ctl_in.clear_n = 1'b1;
      cyc(4);
      step(1'b1);
      cyc(3);
      note(0, 1);
      $display("test clear done");
      incr_mode = 1'b0;
      abs_track = 16'($urandom) | 16'h0200;
      cyc(5);
      note(0, abs_track & 16'hfdff);
      external_zero_option = 1'b0;
      cyc(5);
      note(0, abs_track);
      $display("test absolute done");
      cyc(2);
      close_out();
   end
endmodule : cam_control_input_logic_test
